// *** rtl/link_status_regs.svh ***
`ifndef LINK_STATUS_REGS_SVH
`define LINK_STATUS_REGS_SVH

`define LSC_ADDR_W 15
`define LSC_STATUS_ADDR 15'h006c
`define LSC_CTRL_ADDR 15'h0070
`define LSC_CTRL_RESET 8'h20
`define LSC_ALIGN_BIT 3
`define LSC_PLL_BIT 2
`define LSC_CAL_BIT 1
`define LSC_CLK_BIT 0
`define LSC_TEST_EN_BIT 2
`define LSC_SRC_BIT 0
`define LSC_PAT_POS 16'h66a8
`define LSC_PAT_NEG 16'h9928
`define LSC_PAT_STATIC 16'h66d8
`define LSC_CMD_LAST 5'h0f
`define LSC_FRAME_LAST 5'h17

`endif

// *** rtl/link_status_pkg.sv ***
package link_status_pkg;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD = 2'b01,
    SPI_DATA = 2'b10,
    SPI_DONE = 2'b11
  } spi_state_type;

  typedef struct packed {
    logic clk_present;
    logic cal_done;
    logic pll_lock;
  } status_in_type;

  typedef struct packed {
    logic csb_n;
    logic sclk;
    logic sdi;
  } spi_pins_type;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] lvl_d;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // s1 feeds only s2; a change counts once s2 and s3 agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      lvl_d[i] = lvl_q[i];
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      lvl_q <= RESET_VAL;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;

endmodule
`default_nettype wire

// *** rtl/link_status_and_test_source_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "link_status_regs.svh"
module link_status_and_test_source_ctrl #(
  parameter int CHANNELS = 2
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  input wire logic sysref_i,
  input wire link_status_pkg::status_in_type status_i,
  input wire logic [CHANNELS-1:0][15:0] core_sample_i,
  input wire logic core_valid_i,
  output logic [CHANNELS-1:0][15:0] path_sample_o,
  output logic path_valid_o,
  output logic output_source_select_o,
  output logic test_pattern_enable_o
);

  if (CHANNELS < 1) begin : g_bad_channels
    $error("at least one channel is required");
  end

  // pin synchronisers
  link_status_pkg::spi_pins_type spi_lvl;
  logic [3:0] misc_lvl;
  logic sysref_lvl;
  link_status_pkg::status_in_type status_lvl;

  pin_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_spi_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({spi_csb_n_i, spi_sclk_i, spi_sdi_i}),
    .level_o(spi_lvl)
  );

  // status levels come from analog monitors outside this clock
  pin_sync #(.WIDTH(4), .RESET_VAL(4'h0)) u_misc_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({sysref_i, status_i}),
    .level_o(misc_lvl)
  );

  assign sysref_lvl = misc_lvl[3];
  assign status_lvl = misc_lvl[2:0];
  // edge detection on the filtered levels
  logic sclk_prev_q, sclk_prev_d, sysref_prev_q, sysref_prev_d, sclk_rise, sclk_fall, sysref_rise;
  always_comb begin
    sclk_prev_d = spi_lvl.sclk;
    sysref_prev_d = sysref_lvl;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_prev_q <= 1'b0;
      sysref_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      sysref_prev_q <= sysref_prev_d;
    end
  end
  assign sclk_rise = spi_lvl.sclk & ~sclk_prev_q;
  assign sclk_fall = ~spi_lvl.sclk & sclk_prev_q;
  // no phase-adjust qualification: any rising edge counts
  assign sysref_rise = sysref_lvl & ~sysref_prev_q;

  // register state
  logic align_q, align_d, wr_stb;
  logic [7:0] ctrl_q, ctrl_d, status_byte, wr_data;
  logic [`LSC_ADDR_W-1:0] addr_q, addr_d;

  // bits 7:4 belong to link-layer status kept elsewhere; read zero here
  always_comb begin
    status_byte = 8'h00;
    status_byte[`LSC_ALIGN_BIT] = align_q;
    status_byte[`LSC_PLL_BIT] = status_lvl.pll_lock;
    status_byte[`LSC_CAL_BIT] = status_lvl.cal_done;
    status_byte[`LSC_CLK_BIT] = status_lvl.clk_present;
  end

  function automatic logic [7:0] read_byte(input logic [`LSC_ADDR_W-1:0] a,
                                           input logic [7:0] st,
                                           input logic [7:0] ct);
    logic [7:0] r;
    r = 8'h00;
    if (a == `LSC_STATUS_ADDR) begin
      r = st;
    end else if (a == `LSC_CTRL_ADDR) begin
      r = ct;
    end
    return r;
  endfunction

  always_comb begin
    align_d = align_q;
    ctrl_d = ctrl_q;
    // a zero written to the flag, or to read-only bits, changes nothing
    if (wr_stb && addr_q == `LSC_STATUS_ADDR && wr_data[`LSC_ALIGN_BIT]) begin
      align_d = 1'b0;
    end
    // set after clear: an edge in the clearing cycle is kept
    if (sysref_rise) begin
      align_d = 1'b1;
    end
    // reserved bits are stored as written; the host keeps them at default
    if (wr_stb && addr_q == `LSC_CTRL_ADDR) begin
      ctrl_d = wr_data;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      align_q <= 1'b0;
      ctrl_q <= `LSC_CTRL_RESET;
    end else begin
      align_q <= align_d;
      ctrl_q <= ctrl_d;
    end
  end

  // spi slave: 1 read bit, 15 address bits, 8 data bits, msb first
  link_status_pkg::spi_state_type state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [23:0] shift_q, shift_d;
  logic [7:0] rd_q, rd_d;
  logic is_read_q, is_read_d, sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;

  assign wr_data = {shift_q[6:0], spi_lvl.sdi};

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    is_read_d = is_read_q;
    rd_d = rd_q;
    sdo_d = sdo_q;
    sdo_oe_d = sdo_oe_q;
    wr_stb = 1'b0;
    if (spi_lvl.csb_n) begin
      state_d = link_status_pkg::SPI_IDLE;
      cnt_d = 5'h00;
      sdo_oe_d = 1'b0;
    end else begin
      case (state_q)
        link_status_pkg::SPI_IDLE: begin
          state_d = link_status_pkg::SPI_CMD;
          cnt_d = 5'h00;
        end
        link_status_pkg::SPI_CMD: begin
          if (sclk_rise) begin
            shift_d = {shift_q[22:0], spi_lvl.sdi};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == `LSC_CMD_LAST) begin
              state_d = link_status_pkg::SPI_DATA;
              is_read_d = shift_q[14];
              addr_d = {shift_q[13:0], spi_lvl.sdi};
              // snapshot taken here; later status changes show next frame
              rd_d = read_byte({shift_q[13:0], spi_lvl.sdi}, status_byte, ctrl_q);
            end
          end
        end
        link_status_pkg::SPI_DATA: begin
          if (sclk_fall && is_read_q) begin
            sdo_d = rd_q[7];
            rd_d = {rd_q[6:0], 1'b0};
            sdo_oe_d = 1'b1;
          end
          if (sclk_rise) begin
            shift_d = {shift_q[22:0], spi_lvl.sdi};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == `LSC_FRAME_LAST) begin
              state_d = link_status_pkg::SPI_DONE;
              wr_stb = ~is_read_q;
            end
          end
        end
        link_status_pkg::SPI_DONE: begin
          // extra clocks are ignored until chip select rises
          if (sclk_fall) begin
            sdo_oe_d = 1'b0;
          end
        end
        default: begin
          state_d = link_status_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= link_status_pkg::SPI_IDLE;
      cnt_q <= 5'h00;
      shift_q <= 24'h000000;
      addr_q <= '0;
      is_read_q <= 1'b0;
      rd_q <= 8'h00;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      is_read_q <= is_read_d;
      rd_q <= rd_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
    end
  end

  assign spi_sdo_o = sdo_q;
  assign spi_sdo_oe_o = sdo_oe_q;

  // core data source and test pattern
  logic test_en, src_sel, out_valid_q, out_valid_d;
  logic [1:0] phase_q, phase_d;
  logic [CHANNELS-1:0][15:0] out_q, out_d;

  assign test_en = ctrl_q[`LSC_TEST_EN_BIT];
  assign src_sel = ctrl_q[`LSC_SRC_BIT];

  function automatic logic [15:0] ns_pattern(input logic [1:0] ph);
    logic [15:0] w;
    w = 16'h0000;
    case (ph)
      2'h1: w = `LSC_PAT_POS;
      2'h3: w = `LSC_PAT_NEG;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  always_comb begin
    phase_d = phase_q;
    out_valid_d = core_valid_i;
    if (core_valid_i) begin
      phase_d = phase_q + 2'h1;
    end
  end

  // replacement happens at the core output only; link-layer patterns are untouched
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    always_comb begin
      out_d[c] = out_q[c];
      if (core_valid_i) begin
        out_d[c] = core_sample_i[c];
        if (test_en) begin
          out_d[c] = src_sel ? `LSC_PAT_STATIC : ns_pattern(phase_q);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q <= 2'h0;
      out_q <= '0;
      out_valid_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      out_q <= out_d;
      out_valid_q <= out_valid_d;
    end
  end

  assign path_sample_o = out_q;
  assign path_valid_o = out_valid_q;
  assign output_source_select_o = src_sel;
  assign test_pattern_enable_o = test_en;

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic st_wr, ct_wr;
  assign st_wr = wr_stb && addr_q == `LSC_STATUS_ADDR;
  assign ct_wr = wr_stb && addr_q == `LSC_CTRL_ADDR;
  property p_align_set;
    $rose(sysref_lvl) |=> align_q ##1 (align_q || $past(st_wr && wr_data[`LSC_ALIGN_BIT]));
  endproperty
  a_align_set: assert property (p_align_set) else $error("sysref edge did not set flag");
  property p_align_any_edge;
    sysref_rise && st_wr && wr_data[`LSC_ALIGN_BIT] |=> align_q;
  endproperty
  a_align_any_edge: assert property (p_align_any_edge) else $error("edge lost to clear");
  property p_align_clear;
    st_wr && wr_data[`LSC_ALIGN_BIT] && !sysref_rise ##1 !sysref_rise [*3] |-> !align_q;
  endproperty
  a_align_clear: assert property (p_align_clear) else $error("flag not held clear");
  property p_align_wr0;
    st_wr && !wr_data[`LSC_ALIGN_BIT] && align_q |=> align_q;
  endproperty
  a_align_wr0: assert property (p_align_wr0) else $error("zero write changed flag");
  property p_status_pins;
    $stable(status_i) [*6] |-> status_byte[7:4] == 4'h0 &&
      status_byte[2:0] == {status_i.pll_lock, status_i.cal_done, status_i.clk_present};
  endproperty
  a_status_pins: assert property (p_status_pins) else $error("status bits wrong");
  property p_passthru;
    core_valid_i && !test_en |=> out_q == $past(core_sample_i) && out_valid_q;
  endproperty
  a_passthru: assert property (p_passthru) else $error("core data not passed");
  property p_ns_seq;
    core_valid_i && test_en && !src_sel && phase_q == 2'h1 ##1
      core_valid_i && test_en && !src_sel ##1
      core_valid_i && test_en && !src_sel |=>
      out_q[0] == `LSC_PAT_NEG && $past(out_q[0], 2) == `LSC_PAT_POS;
  endproperty
  a_ns_seq: assert property (p_ns_seq) else $error("tone pattern wrong");
  property p_rs_const;
    core_valid_i && test_en && src_sel |=> out_q[CHANNELS-1] == `LSC_PAT_STATIC;
  endproperty
  a_rs_const: assert property (p_rs_const) else $error("static pattern wrong");
  property p_ctrl_wr;
    ct_wr |=> ctrl_q == $past(wr_data) && output_source_select_o == $past(wr_data[0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
  property p_ro_write;
    st_wr |=> $stable(ctrl_q);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status write leaked");

  c_clear: cover property (st_wr && wr_data[`LSC_ALIGN_BIT] && align_q);
  c_read: cover property (is_read_q && sdo_oe_q);
  c_ns: cover property (core_valid_i && test_en && !src_sel);
  c_rs: cover property (core_valid_i && test_en && src_sel);

endmodule
`default_nettype wire

// *** verif/link_status_and_test_source_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_status_and_test_source_ctrl_tb_top;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic csb_n = 1'b1;
  logic sclk = 1'b0;
  logic sdi = 1'b0;
  logic sysref = 1'b0;
  logic valid = 1'b0;
  link_status_pkg::status_in_type status = '0;
  logic [1:0][15:0] smp = '0;
  logic sdo, sdo_oe, src_sel, test_en, pvalid;
  logic [1:0][15:0] psmp;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int phase = 0;
  logic edge_on_last = 1'b0;

  link_status_and_test_source_ctrl #(.CHANNELS(2)) i_dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .spi_csb_n_i(csb_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .sysref_i(sysref), .status_i(status),
    .core_sample_i(smp), .core_valid_i(valid),
    .path_sample_o(psmp), .path_valid_o(pvalid),
    .output_source_select_o(src_sel), .test_pattern_enable_o(test_en)
  );

  always #4 core_clk_i = ~core_clk_i;

  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // about 30 frames of 400 clocks each; the ceiling leaves ample margin
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_smp(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // sclk half period of 8 core clocks; the pins pass a 3-stage synchroniser
  task automatic half();
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask

  task automatic spi_xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                          output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, addr, wd};
    rdat = '0;
    csb_n = 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      sdi = frame[i];
      half();
      if (i < 8) begin
        rdat[i] = sdo;
        if (rd) chk_bit(sdo_oe, 1'b1, "sdo enable");
      end
      // same pin delay as sclk, so the synced edge meets the write strobe
      if (i == 0 && edge_on_last) sysref = 1'b1;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    csb_n = 1'b1;
    half();
  endtask

  task automatic reg_wr(input logic [14:0] addr, input logic [7:0] wd);
    logic [7:0] dummy;
    spi_xfer(1'b0, addr, wd, dummy);
  endtask

  task automatic reg_rd(input logic [14:0] addr, input logic [7:0] exp, input string what);
    logic [7:0] got;
    spi_xfer(1'b1, addr, 8'h00, got);
    chk_reg(got, exp, what);
  endtask

  // md: 0 input passed, 1 quarter-rate tone, 2 static value
  function automatic logic [15:0] expect_smp(input int md, input logic [15:0] x, input int ph);
    if (md == 0) return x;
    if (md == 2) return 16'd26328;
    if (ph == 1) return 16'd26280;
    if (ph == 3) return 16'(-26328);
    return 16'h0000;
  endfunction

  // the pattern phase advances on every valid sample, enabled or not
  task automatic send(input logic v, input int md, input logic [15:0] x);
    valid = v;
    smp = {~x, x};
    @(posedge core_clk_i);
    #1;
    chk_bit(pvalid, v, "path valid");
    if (v) begin
      chk_smp(psmp[0], expect_smp(md, x, phase), "lane 0");
      chk_smp(psmp[1], expect_smp(md, ~x, phase), "lane 1");
      phase = (phase + 1) % 4;
    end
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    #1;
    arst_n_i = 1'b1;
    half();
    chk_bit(src_sel, 1'b0, "select at reset");
    chk_bit(test_en, 1'b0, "test at reset");
    reg_rd(15'h0070, 8'h20, "ctrl reset");
    for (int i = 0; i < 8; i++) begin
      status = 3'(i);
      reg_rd(15'h006c, {5'h00, i[0], i[1], i[2]}, "status");
    end
    status = 3'b111;
    reg_rd(15'h006c, 8'h07, "cal done");
    sysref = 1'b1;
    half();
    sysref = 1'b0;
    reg_rd(15'h006c, 8'h0f, "aligned");
    reg_wr(15'h006c, 8'h00);
    reg_rd(15'h006c, 8'h0f, "zero write");
    status = 3'b010;
    reg_wr(15'h006c, 8'hf7);
    reg_rd(15'h006c, 8'h0a, "ro bits");
    reg_wr(15'h006c, 8'h08);
    reg_rd(15'h006c, 8'h02, "cleared");
    reg_rd(15'h006c, 8'h02, "stays clear");
    // a level held high must not set the flag again after a clear
    sysref = 1'b1;
    half();
    reg_rd(15'h006c, 8'h0a, "second edge");
    reg_wr(15'h006c, 8'h08);
    reg_rd(15'h006c, 8'h02, "level only");
    sysref = 1'b0;
    // sysref edge lands in the cycle of the clearing write; the set must win
    edge_on_last = 1'b1;
    reg_wr(15'h006c, 8'h08);
    edge_on_last = 1'b0;
    sysref = 1'b0;
    reg_rd(15'h006c, 8'h0a, "set beats clear");
    reg_wr(15'h0071, 8'h5a);
    reg_rd(15'h0071, 8'h00, "unmapped");
    reg_rd(15'h0070, 8'h20, "ctrl kept");
    send(1'b1, 0, 16'h1234);
    send(1'b1, 0, 16'h8001);
    send(1'b0, 0, 16'h0000);
    reg_wr(15'h0070, 8'h24);
    chk_bit(test_en, 1'b1, "test on");
    chk_bit(src_sel, 1'b0, "tone path");
    reg_rd(15'h0070, 8'h24, "ctrl rb");
    for (int k = 0; k < 6; k++) send(1'b1, 1, 16'(k * 4099 + 7));
    send(1'b0, 1, 16'h0000);
    send(1'b1, 1, 16'h0f0f);
    send(1'b0, 1, 16'h0000);
    reg_wr(15'h0070, 8'h25);
    chk_bit(src_sel, 1'b1, "static path");
    for (int k = 0; k < 3; k++) send(1'b1, 2, 16'(k * 777 + 3));
    send(1'b0, 2, 16'h0000);
    reg_wr(15'h0070, 8'h21);
    chk_bit(test_en, 1'b0, "test off");
    chk_bit(src_sel, 1'b1, "select kept");
    for (int k = 0; k < 3; k++) send(1'b1, 0, 16'(k * 9001 + 5));
    send(1'b0, 0, 16'h0000);
    reg_rd(15'h0070, 8'h21, "ctrl final");
    close_out();
  end
endmodule
`default_nettype wire
